// ==== design/portd_ctrl_pkg.sv ====
// constants for the port d override and mcu control block
package portd_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // register decode: data space and i/o space views
  localparam logic [7:0] MCU_CONTROL_DATA_ADDR = 8'h0055;
  localparam logic [7:0] IO_SPACE_BASE = 8'h0020;
  localparam logic [7:0] MCU_CONTROL_IO_ADDR = 8'h0035;
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h0000;
  // field positions
  localparam int unsigned DEBUG_DISABLE_BIT = 7;
  localparam int unsigned BOD_SLEEP_BIT = 6;
  localparam int unsigned BOD_UNLOCK_BIT = 5;
  localparam int unsigned PULLUP_OFF_BIT = 4;
  localparam int unsigned VECTOR_SELECT_BIT = 1;
  localparam int unsigned VECTOR_UNLOCK_BIT = 0;
  // timed sequence windows, in clock cycles
  localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'h4;
  localparam logic [2:0] BOD_SLEEP_CYCLES = 3'h3;
  // pin positions on port d
  localparam int unsigned PIN_SERIAL0_RX = 0;
  localparam int unsigned PIN_SERIAL0_TX = 1;
  localparam int unsigned PIN_SERIAL1_RX = 2;
  localparam int unsigned PIN_SERIAL1_TX = 3;
  localparam int unsigned PIN_T1_COMPARE_B = 4;
  localparam int unsigned PIN_T1_COMPARE_A = 5;
  localparam int unsigned PIN_T2_COMPARE_B = 6;
  localparam int unsigned PIN_T2_COMPARE_A = 7;
endpackage

// ==== design/portd_override.sv ====
// port d alternate-function overrides and mcu control register
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - tx enable forces output, drives tx data
// - rx enable forces input, routes pin
// - rx pin pull-up follows data bit
// - compare outputs replace value, not direction
// - pin-change mask and group force input buffer
// - pins 3/2 feed external irqs one/zero
// - debug port enabled by fuse unless disabled
// - debug disable changes on double write
// - bod sleep set via two-write sequence
// - bod sleep effective for sleep instruction
// - bod sleep clears after three cycles
// - global pull-up off kills all pull-ups
// - vector select picks app or boot base
// - vector select changes only after unlock
// - interrupts blocked during vector sequence
// - blocking leaves global interrupt flag alone
// - vector unlock clears after four cycles
// - boot locks suppress interrupts by section
// - decode at data 0x55 and io 0x35
module portd_override (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // cpu register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_io_space,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // port registers of port d
  input wire logic [7:0] portd_dir,
  input wire logic [7:0] portd_data,
  // pin pad
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n,
  output logic [7:0] pad_pullup,
  output logic [7:0] pad_input_en,
  output logic [7:0] pin_level,
  // serial units
  input wire logic serial0_tx_enable,
  input wire logic serial0_rx_enable,
  input wire logic serial1_tx_enable,
  input wire logic serial1_rx_enable,
  input wire logic serial0_tx_pin,
  input wire logic serial1_tx_pin,
  output logic serial0_rx_pin,
  output logic serial1_rx_pin,
  // timers
  input wire logic [3:0] compare_enable,
  input wire logic timer1_compare_b_out,
  input wire logic timer1_compare_a_out,
  input wire logic timer2_compare_b_out,
  input wire logic timer2_compare_a_out,
  output logic timer1_capture_in,
  // interrupt sources
  input wire logic [7:0] pin_change_mask,
  input wire logic pin_change_group3_enable,
  input wire logic ext_irq_zero_enable,
  input wire logic ext_irq_one_enable,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  // debug, brown-out, vectors
  input wire logic debug_port_fuse,
  input wire logic sleep_exec,
  input wire logic exec_in_boot,
  input wire logic app_boot_lock,
  input wire logic boot_section_lock,
  input wire logic [15:0] boot_base_addr,
  output logic debug_port_enable,
  output logic brownout_sleep_off,
  output logic brownout_off_in_sleep,
  output logic [15:0] vector_base,
  output logic irq_block
);
  logic debug_port_disable_r;
  logic bod_sleep_r;
  logic bod_unlock_r;
  logic global_pullup_off_r;
  logic vector_table_select_r;
  logic vector_change_unlock_r;
  logic [7:0] dbg_pending_r;
  logic [2:0] bod_age_r;
  logic post_sel_r;
  logic hit;
  logic wr_hit;
  logic vec_open;
  logic bod_open;
  logic dbg_open;
  logic [7:0] rdata_nxt;
  logic [7:0] comp_val;

  // either address view reaches the register
  function automatic logic addr_match(input logic [7:0] a,
                                      input logic io);
    addr_match = io ? (a == portd_ctrl_pkg::MCU_CONTROL_IO_ADDR)
                    : (a == portd_ctrl_pkg::MCU_CONTROL_DATA_ADDR);
  endfunction

  assign hit = addr_match(reg_addr, reg_io_space);
  assign wr_hit = hit && reg_wr;

  // timed windows share one counter shape
  seq_window u_vec_win (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(wr_hit && reg_wdata[portd_ctrl_pkg::VECTOR_UNLOCK_BIT]),
    .cancel(wr_hit && !reg_wdata[portd_ctrl_pkg::VECTOR_UNLOCK_BIT]),
    // one short: the unlock flop itself covers the write cycle
    .length(portd_ctrl_pkg::UNLOCK_WINDOW_CYCLES - 3'h1),
    .open(vec_open)
  );
  seq_window u_bod_win (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(wr_hit && reg_wdata[portd_ctrl_pkg::BOD_SLEEP_BIT]
           && reg_wdata[portd_ctrl_pkg::BOD_UNLOCK_BIT]),
    .cancel(1'b0),
    .length(portd_ctrl_pkg::UNLOCK_WINDOW_CYCLES),
    .open(bod_open)
  );
  seq_window u_dbg_win (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(wr_hit && !dbg_open),
    .cancel(wr_hit && dbg_open),
    .length(portd_ctrl_pkg::UNLOCK_WINDOW_CYCLES),
    .open(dbg_open)
  );

  // debug disable: first write arms, second equal write commits
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      debug_port_disable_r <= 1'b0;
      dbg_pending_r <= portd_ctrl_pkg::MCU_CONTROL_RESET;
    end else if (clk_en && wr_hit) begin
      dbg_pending_r <= reg_wdata;
      if (dbg_open && dbg_pending_r[portd_ctrl_pkg::DEBUG_DISABLE_BIT]
          == reg_wdata[portd_ctrl_pkg::DEBUG_DISABLE_BIT]) begin
        debug_port_disable_r <=
          reg_wdata[portd_ctrl_pkg::DEBUG_DISABLE_BIT];
      end
    end
  end

  // pull-up disable is a plain bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      global_pullup_off_r <= 1'b0;
    end else if (clk_en && wr_hit) begin
      global_pullup_off_r <= reg_wdata[portd_ctrl_pkg::PULLUP_OFF_BIT];
    end
  end

  // brown-out sleep: unlock then commit, self-clears after three
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bod_unlock_r <= 1'b0;
      bod_sleep_r <= 1'b0;
      bod_age_r <= 3'h0;
    end else if (clk_en) begin
      if (wr_hit && bod_open && reg_wdata[portd_ctrl_pkg::BOD_SLEEP_BIT]
          && !reg_wdata[portd_ctrl_pkg::BOD_UNLOCK_BIT]) begin
        bod_sleep_r <= 1'b1;
        bod_unlock_r <= 1'b0;
        bod_age_r <= portd_ctrl_pkg::BOD_SLEEP_CYCLES;
      end else begin
        if (wr_hit) begin
          bod_unlock_r <= reg_wdata[portd_ctrl_pkg::BOD_UNLOCK_BIT]
                          && reg_wdata[portd_ctrl_pkg::BOD_SLEEP_BIT];
        end else if (!bod_open) begin
          bod_unlock_r <= 1'b0;
        end
        if (bod_age_r != 3'h0) begin
          bod_age_r <= bod_age_r - 3'h1;
        end
        if (bod_age_r == 3'h1) begin
          bod_sleep_r <= 1'b0;
        end
      end
    end
  end

  // vector select commit; unlock self-clears with the window
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vector_table_select_r <= 1'b0;
      vector_change_unlock_r <= 1'b0;
      post_sel_r <= 1'b0;
    end else if (clk_en) begin
      post_sel_r <= 1'b0;
      if (wr_hit && reg_wdata[portd_ctrl_pkg::VECTOR_UNLOCK_BIT]) begin
        vector_change_unlock_r <= 1'b1;
      end else if (wr_hit && vector_change_unlock_r) begin
        vector_table_select_r <=
          reg_wdata[portd_ctrl_pkg::VECTOR_SELECT_BIT];
        vector_change_unlock_r <= 1'b0;
        post_sel_r <= 1'b1; // hold block over next instruction
      end else if (!vec_open) begin
        vector_change_unlock_r <= 1'b0;
      end
    end
  end

  // readback; bits 3 and 2 always zero
  always_comb begin
    rdata_nxt = portd_ctrl_pkg::MCU_CONTROL_RESET;
    rdata_nxt[portd_ctrl_pkg::DEBUG_DISABLE_BIT] = debug_port_disable_r;
    rdata_nxt[portd_ctrl_pkg::BOD_SLEEP_BIT] = bod_sleep_r;
    rdata_nxt[portd_ctrl_pkg::BOD_UNLOCK_BIT] = bod_unlock_r;
    rdata_nxt[portd_ctrl_pkg::PULLUP_OFF_BIT] = global_pullup_off_r;
    rdata_nxt[portd_ctrl_pkg::VECTOR_SELECT_BIT] = vector_table_select_r;
    rdata_nxt[portd_ctrl_pkg::VECTOR_UNLOCK_BIT] = vector_change_unlock_r;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= portd_ctrl_pkg::MCU_CONTROL_RESET;
    end else if (clk_en) begin
      reg_rdata <= (hit && reg_rd) ? rdata_nxt
                   : portd_ctrl_pkg::MCU_CONTROL_RESET;
    end
  end

  // compare values in pin order 4..7
  assign comp_val = {timer2_compare_a_out, timer2_compare_b_out,
                     timer1_compare_a_out, timer1_compare_b_out, 4'h0};

  // pad overrides, registered so every output is a flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pad_out <= 8'h00;
      pad_oe_n <= 8'hFF;
      pad_pullup <= 8'h00;
      pad_input_en <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 8; i++) begin
        pad_oe_n[i] <= !portd_dir[i];
        pad_out[i] <= portd_data[i];
        pad_pullup[i] <= !portd_dir[i] && portd_data[i]
                         && !global_pullup_off_r;
        pad_input_en[i] <= pin_change_mask[i]
                           && pin_change_group3_enable;
      end
      for (int i = 4; i < 8; i++) begin
        if (compare_enable[i - 4]) begin
          pad_out[i] <= comp_val[i];
        end
      end
      if (serial0_tx_enable) begin
        pad_oe_n[portd_ctrl_pkg::PIN_SERIAL0_TX] <= 1'b0;
        pad_out[portd_ctrl_pkg::PIN_SERIAL0_TX] <= serial0_tx_pin;
        pad_pullup[portd_ctrl_pkg::PIN_SERIAL0_TX] <= 1'b0;
      end
      if (serial1_tx_enable) begin
        pad_oe_n[portd_ctrl_pkg::PIN_SERIAL1_TX] <= 1'b0;
        pad_out[portd_ctrl_pkg::PIN_SERIAL1_TX] <= serial1_tx_pin;
        pad_pullup[portd_ctrl_pkg::PIN_SERIAL1_TX] <= 1'b0;
      end
      if (serial0_rx_enable) begin
        pad_oe_n[portd_ctrl_pkg::PIN_SERIAL0_RX] <= 1'b1;
        pad_pullup[portd_ctrl_pkg::PIN_SERIAL0_RX] <=
          portd_data[portd_ctrl_pkg::PIN_SERIAL0_RX]
          && !global_pullup_off_r;
      end
      if (serial1_rx_enable) begin
        pad_oe_n[portd_ctrl_pkg::PIN_SERIAL1_RX] <= 1'b1;
        pad_pullup[portd_ctrl_pkg::PIN_SERIAL1_RX] <=
          portd_data[portd_ctrl_pkg::PIN_SERIAL1_RX]
          && !global_pullup_off_r;
      end
      if (ext_irq_one_enable) begin
        pad_input_en[portd_ctrl_pkg::PIN_SERIAL1_TX] <= 1'b1;
      end
      if (ext_irq_zero_enable) begin
        pad_input_en[portd_ctrl_pkg::PIN_SERIAL1_RX] <= 1'b1;
      end
    end
  end

  // pin levels to internal consumers, one register stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_level <= 8'h00;
      serial0_rx_pin <= 1'b1;
      serial1_rx_pin <= 1'b1;
      ext_irq_zero <= 1'b0;
      ext_irq_one <= 1'b0;
      timer1_capture_in <= 1'b0;
    end else if (clk_en) begin
      pin_level <= pad_in;
      serial0_rx_pin <= pad_in[portd_ctrl_pkg::PIN_SERIAL0_RX];
      serial1_rx_pin <= pad_in[portd_ctrl_pkg::PIN_SERIAL1_RX];
      ext_irq_zero <= pad_in[portd_ctrl_pkg::PIN_SERIAL1_RX];
      ext_irq_one <= pad_in[portd_ctrl_pkg::PIN_SERIAL1_TX];
      timer1_capture_in <= pad_in[portd_ctrl_pkg::PIN_T2_COMPARE_B];
    end
  end

  // system control outputs; blocking never touches the i flag
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      debug_port_enable <= 1'b0;
      brownout_sleep_off <= 1'b0;
      brownout_off_in_sleep <= 1'b0;
      vector_base <= 16'h0000;
      irq_block <= 1'b0;
    end else if (clk_en) begin
      debug_port_enable <= debug_port_fuse && !debug_port_disable_r;
      brownout_sleep_off <= bod_sleep_r;
      brownout_off_in_sleep <= sleep_exec && bod_sleep_r;
      vector_base <= vector_table_select_r ? boot_base_addr
                                           : 16'h0000;
      irq_block <= vector_change_unlock_r || post_sel_r
                   || (vector_table_select_r && app_boot_lock
                       && !exec_in_boot)
                   || (!vector_table_select_r && boot_section_lock
                       && exec_in_boot);
    end
  end
endmodule // portd_override
`default_nettype wire

// ==== design/seq_window.sv ====
// small down counter that holds a timed-sequence window open
`timescale 1ns/10ps
`default_nettype none
module seq_window (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic start,
  input wire logic cancel,
  input wire logic [2:0] length,
  output logic open
);
  logic [2:0] count_r;
  // start wins over cancel so a fresh unlock is never lost
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_r <= 3'h0;
    end else if (clk_en) begin
      if (start) begin
        count_r <= length;
      end else if (cancel) begin
        count_r <= 3'h0;
      end else if (count_r != 3'h0) begin
        count_r <= count_r - 3'h1;
      end
    end
  end
  assign open = (count_r != 3'h0);
endmodule // seq_window
`default_nettype wire

// ==== dv/periph_model.sv ====
// stand-in for serial, timer and pad activity around port d
`timescale 1ns/10ps
`default_nettype none
module periph_model (
  input wire logic sys_clk,
  output logic [1:0] tx_bits,
  output logic [3:0] cmp_bits,
  output logic [7:0] pad_lvl
);
  logic [7:0] cnt_r = 8'h00;
  // changes every cycle so a stale or stuck pad value shows up
  always_ff @(posedge sys_clk) cnt_r <= #2 cnt_r + 8'h01;
  assign tx_bits = {cnt_r[0], ~cnt_r[0]};
  assign cmp_bits = cnt_r[3:0] ^ 4'h5;
  assign pad_lvl = cnt_r ^ {cnt_r[6:0], 1'b1};
endmodule // periph_model
`default_nettype wire

// ==== dv/port_d_override_and_mcu_control_tb.sv ====
// bench for the port d override and mcu control block
`timescale 1ns/10ps
`default_nettype none
module port_d_override_and_mcu_control_tb;
  localparam logic [7:0] DA = portd_ctrl_pkg::MCU_CONTROL_DATA_ADDR;
  localparam logic [7:0] IA = portd_ctrl_pkg::MCU_CONTROL_IO_ADDR;
  localparam logic [15:0] BOOT_BASE = 16'h7000;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
  logic reg_io_space = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pad_in;
  logic [7:0] portd_dir = 8'h00, portd_data = 8'h00;
  logic [7:0] pin_change_mask = 8'h00, pin_level;
  logic [7:0] pad_out, pad_oe_n, pad_pullup, pad_input_en;
  logic [3:0] compare_enable = 4'h0, cmp_bits;
  logic [1:0] tx_bits;
  logic serial0_tx_enable = 1'b0, serial0_rx_enable = 1'b0;
  logic serial1_tx_enable = 1'b0, serial1_rx_enable = 1'b0;
  logic serial0_rx_pin, serial1_rx_pin, timer1_capture_in;
  logic pin_change_group3_enable = 1'b0, ext_irq_zero_enable = 1'b0;
  logic ext_irq_one_enable = 1'b0, ext_irq_zero, ext_irq_one;
  logic sleep_exec = 1'b0, exec_in_boot = 1'b0, app_boot_lock = 1'b0;
  logic boot_section_lock = 1'b0, debug_port_enable, brownout_sleep_off;
  logic brownout_off_in_sleep, irq_block;
  logic debug_port_fuse = 1'b1;
  logic [15:0] vector_base;
  int mismatches = 0, n_compared = 0, hi, seen, blk;
  periph_model u_periph_model (.sys_clk(sys_clk), .tx_bits(tx_bits),
    .cmp_bits(cmp_bits), .pad_lvl(pad_in));
  portd_override u_portd_override (.*, .serial0_tx_pin(tx_bits[0]),
    .serial1_tx_pin(tx_bits[1]), .timer1_compare_b_out(cmp_bits[0]),
    .timer1_compare_a_out(cmp_bits[1]), .timer2_compare_b_out(cmp_bits[2]),
    .timer2_compare_a_out(cmp_bits[3]), .boot_base_addr(BOOT_BASE));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // writes land on consecutive edges, keeping timed sequences tight
  task automatic wr(input logic io, input logic [7:0] d[$]);
    foreach (d[i]) begin
      reg_io_space = io;
      reg_addr = io ? IA : DA;
      reg_wdata = d[i];
      reg_wr = 1'b1;
      cyc(1);
    end
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] e);
    reg_io_space = io;
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    chk(reg_rdata, e);
    reg_rd = 1'b0;
    cyc(1);
  endtask
  // counts high cycles; pulses sleep once the bod bit is seen
  task automatic watch(input int n);
    hi = 0;
    seen = 0;
    blk = 0;
    repeat (n) begin
      sleep_exec = brownout_sleep_off && hi == 0;
      hi += int'(brownout_sleep_off === 1'b1);
      seen += int'(brownout_off_in_sleep === 1'b1);
      blk += int'(irq_block === 1'b1);
      cyc(1);
    end
    sleep_exec = 1'b0;
  endtask
  task automatic pads(input logic [1:0] tx, rx, irq,
    input logic [7:0] dir, dat, msk, input logic grp,
    input logic [7:0] oe, pu, ie);
    {serial1_tx_enable, serial0_tx_enable} = tx;
    {serial1_rx_enable, serial0_rx_enable} = rx;
    {ext_irq_one_enable, ext_irq_zero_enable} = irq;
    portd_dir = dir;
    portd_data = dat;
    pin_change_mask = msk;
    pin_change_group3_enable = grp;
    cyc(2);
    chk(pad_oe_n, oe);
    chk(pad_pullup, pu);
    chk(pad_input_en, ie);
    chk(pin_level, pad_in);
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up;
  end
  initial begin
    cyc(12);
    sys_rst = 1'b0;
    rd(1'b0, DA, 8'h00);
    portd_data = 8'hff;
    wr(1'b0, '{8'h1c});
    rd(1'b1, IA, 8'h10);
    chk(pad_pullup, 8'h00);
    rd(1'b0, 8'h56, 8'h00);
    rd(1'b1, DA, 8'h00);
    wr(1'b0, '{8'h00});
    cyc(2);
    chk(pad_pullup, 8'hff);
    $display("test register_access done");
    pads(2'b11, 2'b00, 2'b01, 8'h00, 8'hff, 8'hf0, 1'b1, 8'hf5, 8'hf5, 8'hf4);
    chk({pad_out[3], pad_out[1]}, tx_bits);
    pads(2'b00, 2'b11, 2'b10, 8'hff, 8'h01, 8'h0f, 1'b0, 8'h05, 8'h01, 8'h08);
    chk({timer1_capture_in, ext_irq_one, ext_irq_zero, serial1_rx_pin,
      serial0_rx_pin}, {pad_in[6], pad_in[3:2], pad_in[2], pad_in[0]});
    compare_enable = 4'hf;
    pads(2'b00, 2'b00, 2'b00, 8'hf0, 8'h0f, 8'hff, 1'b1, 8'h0f, 8'h0f, 8'hff);
    chk(pad_out[7:4], cmp_bits);
    $display("test pin_overrides done");
    debug_port_fuse = 1'b0;
    cyc(2);
    chk(debug_port_enable, 1'b0);
    debug_port_fuse = 1'b1;
    cyc(2);
    chk(debug_port_enable, 1'b1);
    wr(1'b0, '{8'h80});
    rd(1'b0, DA, 8'h00);
    cyc(6);
    wr(1'b0, '{8'h80, 8'h80});
    rd(1'b0, DA, 8'h80);
    chk(debug_port_enable, 1'b0);
    wr(1'b0, '{8'h00, 8'h00});
    rd(1'b0, DA, 8'h00);
    $display("test debug_disable done");
    wr(1'b0, '{8'h60});
    watch(8);
    chk(16'(hi), 16'h0000);
    wr(1'b0, '{8'h60, 8'h40});
    watch(8);
    chk(16'(hi), 16'(portd_ctrl_pkg::BOD_SLEEP_CYCLES));
    chk(16'(seen > 0), 16'h0001);
    $display("test brownout_sleep done");
    wr(1'b1, '{8'h02});
    rd(1'b1, IA, 8'h00);
    wr(1'b1, '{8'h01});
    watch(8);
    chk(16'(blk), 16'(portd_ctrl_pkg::UNLOCK_WINDOW_CYCLES));
    rd(1'b1, IA, 8'h00);
    wr(1'b1, '{8'h02});
    rd(1'b1, IA, 8'h00);
    wr(1'b1, '{8'h01, 8'h02});
    rd(1'b1, IA, 8'h02);
    chk(vector_base, BOOT_BASE);
    app_boot_lock = 1'b1;
    cyc(2);
    chk(irq_block, 1'b1);
    exec_in_boot = 1'b1;
    cyc(2);
    chk(irq_block, 1'b0);
    app_boot_lock = 1'b0;
    boot_section_lock = 1'b1;
    wr(1'b1, '{8'h01, 8'h00});
    cyc(3);
    chk(vector_base, 16'h0000);
    chk(irq_block, 1'b1);
    exec_in_boot = 1'b0;
    cyc(2);
    chk(irq_block, 1'b0);
    $display("test vector_select done");
    // a write while frozen must not land
    clk_en = 1'b0;
    wr(1'b0, '{8'h10});
    clk_en = 1'b1;
    rd(1'b0, DA, 8'h00);
    $display("test clock_enable done");
    wrap_up;
  end
endmodule // port_d_override_and_mcu_control_tb
`default_nettype wire

// ==== dv/portd_override_asserts.sv ====
// port-level assertions for the port d override block
`timescale 1ns/10ps
`default_nettype none
module portd_override_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic serial1_tx_enable,
  input wire logic serial1_rx_enable,
  input wire logic serial1_tx_pin,
  input wire logic [7:0] portd_data,
  input wire logic [3:0] compare_enable,
  input wire logic timer1_compare_a_out,
  input wire logic [7:0] pin_change_mask,
  input wire logic pin_change_group3_enable,
  input wire logic ext_irq_one_enable,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] pad_input_en,
  input wire logic ext_irq_one,
  input wire logic debug_port_fuse,
  input wire logic debug_port_enable,
  input wire logic brownout_sleep_off,
  input wire logic irq_block,
  input wire logic app_boot_lock,
  input wire logic boot_section_lock,
  input wire logic [15:0] vector_base,
  input wire logic [15:0] boot_base_addr
);
  logic live_r;
  // last edge was live, so registered pads reflect the past inputs
  always_ff @(posedge sys_clk) live_r <= !sys_rst && clk_en;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // both timed windows must close on their own
  sequence bod_end; ##[1:4] !brownout_sleep_off; endsequence
  sequence blk_end; ##[1:6] !irq_block; endsequence
  a_tx_drives_pin: assert property (
    live_r && $past(serial1_tx_enable) |-> !pad_oe_n[3] && !pad_pullup[3]
    && pad_out[3] == $past(serial1_tx_pin)) else $error("tx pin idle");
  a_rx_forced_in: assert property (
    live_r && $past(serial1_rx_enable) |-> pad_oe_n[2])
    else $error("rx pin driven");
  a_rx_pullup_data: assert property (
    live_r && $past(serial1_rx_enable && !portd_data[2]) |-> !pad_pullup[2])
    else $error("rx pullup wrong");
  a_cmp_value_out: assert property (
    live_r && $past(compare_enable[1])
    |-> pad_out[5] == $past(timer1_compare_a_out)) else $error("cmp lost");
  a_pcint_input_on: assert property (
    live_r && $past(pin_change_mask[4] && pin_change_group3_enable)
    |-> pad_input_en[4]) else $error("pcint input off");
  a_ext_irq_route: assert property (
    live_r |-> ext_irq_one == $past(pad_in[3])
    && (pad_input_en[3] || !$past(ext_irq_one_enable)))
    else $error("ext irq route");
  a_debug_needs_fuse: assert property (
    live_r && debug_port_enable |-> $past(debug_port_fuse))
    else $error("debug without fuse");
  a_bod_self_clear: assert property (
    $rose(brownout_sleep_off) |-> bod_end) else $error("bod stuck");
  // lock-driven blocking is a level that may stand, so leave it out
  a_block_bounded: assert property (
    $rose(irq_block) && !$past(app_boot_lock || boot_section_lock)
    |-> blk_end) else $error("irq block stuck");
  a_vector_base_sel: assert property (
    live_r |-> vector_base == 16'h0000
    || vector_base == $past(boot_base_addr)) else $error("bad base");
  a_rdata_idle_zero: assert property (
    live_r && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata not idle");
endmodule // portd_override_asserts
bind portd_override portd_override_asserts u_portd_override_asserts (.*);
`default_nettype wire
